// file: core/pio_params.svh
// constants for the per-output intensity pwm block
// Notes on behaviour
// RULE_01 - 0x10 holds output 1 high, 0 low
// RULE_02 - 0x11 holds output 3 high, 2 low
// RULE_03 - 0x12 holds output 5 high, 4 low
// RULE_04 - 0x13 holds output 7 high, 6 low
// RULE_05 - codes 0..14 give duty (code+1)/16
// RULE_06 - code all ones holds static, no pwm
// RULE_07 - reads return codes last written, same bits
// RULE_08 - output 8 code in low nibble of 0x0e
// RULE_09 - master zero stops oscillator, outputs static
// RULE_10 - new codes take effect at period start
`ifndef PIO_PARAMS_SVH
`define PIO_PARAMS_SVH

// register addresses
`define PIO_ADDR_MASTER 8'h0e
`define PIO_ADDR_PAIR10 8'h10
`define PIO_ADDR_PAIR32 8'h11
`define PIO_ADDR_PAIR54 8'h12
`define PIO_ADDR_PAIR76 8'h13

// storage indices
`define PIO_IDX_MASTER 3'h0
`define PIO_IDX_PAIR10 3'h1
`define PIO_IDX_PAIR32 3'h2
`define PIO_IDX_PAIR54 3'h3
`define PIO_IDX_PAIR76 3'h4
`define PIO_NUM_WORDS 5

// field layout
`define PIO_NIB_W 4
`define PIO_HI_LSB 4
`define PIO_LO_LSB 0

// values
`define PIO_WORD_RESET 8'h00
`define PIO_READ_UNMAPPED 8'h00
`define PIO_CODE_STATIC 4'hf
`define PIO_MASTER_OFF 4'h0
`define PIO_MASTER_FULL 4'hf

// pwm timing
`define PIO_SLOT_LAST 4'hf
`define PIO_SUB_LAST 4'he
`define PIO_TICK_DIV 1
`define PIO_NUM_OUT 9

`endif

// file: core/pio_pkg.sv
// types of the per-output intensity pwm block
package pio_pkg;
    typedef logic [3:0] pio_code_t;
    typedef logic [7:0] pio_word_t;
    typedef logic [2:0] pio_idx_t;
endpackage

// file: core/pio_mem_if.sv
// carrier between the control logic and the register storage
`include "pio_params.svh"
interface pio_mem_if;
    logic wrEn; // write strobe
    pio_pkg::pio_idx_t wrIdx; // write index
    pio_pkg::pio_word_t wrData; // write data
    logic rdEn; // read strobe
    logic rdHit; // read address mapped
    pio_pkg::pio_idx_t rdIdx; // read index
    pio_pkg::pio_word_t rdData; // registered read data
    pio_pkg::pio_word_t [`PIO_NUM_WORDS-1:0] words; // all stored words
    modport ctrl (output wrEn, wrIdx, wrData, rdEn, rdHit, rdIdx, input rdData, words);
    modport mem (input wrEn, wrIdx, wrData, rdEn, rdHit, rdIdx, output rdData, words);
endinterface

// file: core/pio_reg_mem.sv
// storage of the intensity words with registered read port
`include "pio_params.svh"
module pio_reg_mem (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // storage port
    pio_mem_if.mem memIf
);
    pio_pkg::pio_word_t [`PIO_NUM_WORDS-1:0] words_ff; // stored words

    // write port, unmapped writes never reach here
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            words_ff <= {`PIO_NUM_WORDS{`PIO_WORD_RESET}};
        end else if (memIf.wrEn) begin
            words_ff[memIf.wrIdx] <= memIf.wrData;
        end
    end

    // read port, old value if written same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            memIf.rdData <= `PIO_READ_UNMAPPED;
        end else if (memIf.rdEn) begin
            memIf.rdData <= memIf.rdHit ? words_ff[memIf.rdIdx] : `PIO_READ_UNMAPPED; // RULE_07
        end
    end

    // all words for the pwm logic
    assign memIf.words = words_ff;
endmodule

// file: core/pio_top.sv
// per-output intensity pwm: register port, period counters, output drive
`include "pio_params.svh"
module pio_top #(
    parameter int TICK_DIV = `PIO_TICK_DIV // clocks per pwm sub-step
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register access port, after serial decode
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    output logic regRdValid,
    // open-drain led ports, index 0..8
    output logic [`PIO_NUM_OUT-1:0] ledPortOut,
    output logic [`PIO_NUM_OUT-1:0] ledPortOe
);
    localparam int TW = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;

    // refuse a divider the prescaler cannot serve
    generate
        if (TICK_DIV < 1) begin : g_bad_div
            $error("TICK_DIV must be at least one");
        end
    endgenerate

    pio_mem_if memIf(); // storage carrier

    // address decode into hit flag and storage index
    function automatic logic [3:0] decodeAddr(input logic [7:0] a);
        case (a)
            `PIO_ADDR_MASTER: decodeAddr = {1'b1, `PIO_IDX_MASTER}; // RULE_08
            `PIO_ADDR_PAIR10: decodeAddr = {1'b1, `PIO_IDX_PAIR10}; // RULE_01
            `PIO_ADDR_PAIR32: decodeAddr = {1'b1, `PIO_IDX_PAIR32}; // RULE_02
            `PIO_ADDR_PAIR54: decodeAddr = {1'b1, `PIO_IDX_PAIR54}; // RULE_03
            `PIO_ADDR_PAIR76: decodeAddr = {1'b1, `PIO_IDX_PAIR76}; // RULE_04
            default: decodeAddr = 4'h0;
        endcase
    endfunction

    logic [3:0] wrDec; // write decode
    logic [3:0] rdDec; // read decode
    assign wrDec = decodeAddr(regAddr);
    assign rdDec = decodeAddr(regAddr);

    // storage port drive, unmapped writes dropped
    assign memIf.wrEn = regWrEn && wrDec[3];
    assign memIf.wrIdx = wrDec[2:0];
    assign memIf.wrData = regWrData;
    assign memIf.rdEn = regRdEn;
    assign memIf.rdHit = rdDec[3];
    assign memIf.rdIdx = rdDec[2:0];

    pio_reg_mem u_mem (
        .clk(clk),
        .rst_n(rst_n),
        .memIf(memIf)
    );

    // read data comes from the storage register
    assign regRdData = memIf.rdData;

    // read valid one cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRdEn;
        end
    end

    pio_pkg::pio_code_t storedMaster; // master field as written
    logic oscOff; // oscillator stopped
    assign storedMaster = memIf.words[`PIO_IDX_MASTER][`PIO_HI_LSB +: `PIO_NIB_W];
    assign oscOff = (storedMaster == `PIO_MASTER_OFF); // RULE_09

    // prescaler, held while the oscillator is stopped
    logic [TW-1:0] preCnt_ff;
    logic tick; // one sub-step elapsed
    assign tick = (preCnt_ff == TW'(TICK_DIV - 1));
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            preCnt_ff <= '0;
        end else if (oscOff || tick) begin
            preCnt_ff <= '0;
        end else begin
            preCnt_ff <= preCnt_ff + TW'(1);
        end
    end

    // slot counts sixteenths, sub splits each slot into fifteenths
    pio_pkg::pio_code_t slot_ff;
    pio_pkg::pio_code_t sub_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slot_ff <= 4'h0;
            sub_ff <= 4'h0;
        end else if (oscOff) begin
            slot_ff <= 4'h0;
            sub_ff <= 4'h0;
        end else if (tick) begin
            if (sub_ff == `PIO_SUB_LAST) begin
                sub_ff <= 4'h0;
                slot_ff <= slot_ff + 4'h1;
            end else begin
                sub_ff <= sub_ff + 4'h1;
            end
        end
    end

    logic periodStart; // load point for new settings
    assign periodStart = oscOff || (tick && slot_ff == `PIO_SLOT_LAST && sub_ff == `PIO_SUB_LAST);

    // master setting held for a whole period
    pio_pkg::pio_code_t activeMaster_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            activeMaster_ff <= `PIO_MASTER_OFF;
        end else if (periodStart) begin
            activeMaster_ff <= storedMaster; // RULE_10
        end
    end

    pio_pkg::pio_code_t [`PIO_NUM_OUT-1:0] activeCode_ff; // latched codes
    logic [`PIO_NUM_OUT-1:0] ledOn; // sink wanted this cycle

    // per output: code select, latch and duty compare
    generate
        for (genvar i = 0; i < `PIO_NUM_OUT; i++) begin : g_out
            pio_pkg::pio_code_t storedCode; // code as written
            if (i == `PIO_NUM_OUT - 1) begin : g_nine
                assign storedCode =
                    memIf.words[`PIO_IDX_MASTER][`PIO_LO_LSB +: `PIO_NIB_W]; // RULE_08
            end else begin : g_pair
                // odd outputs upper nibble, even lower
                assign storedCode = memIf.words[i / 2 + 1][(i % 2) * 4 +: `PIO_NIB_W];
            end
            // latch only at period start
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    activeCode_ff[i] <= 4'h0;
                end else if (periodStart) begin
                    activeCode_ff[i] <= storedCode; // RULE_10
                end
            end
            // duty: slots 0..code on, gated by master fifteenths
            always_comb begin
                if (activeMaster_ff == `PIO_MASTER_OFF) begin
                    ledOn[i] = 1'b0; // RULE_09
                end else if (activeCode_ff[i] == `PIO_CODE_STATIC) begin
                    ledOn[i] = 1'b1; // RULE_06
                end else begin
                    ledOn[i] = (slot_ff <= activeCode_ff[i]) && (sub_ff < activeMaster_ff); // RULE_05
                end
            end
        end
    endgenerate

    // pin drive, open-drain sinks low when enabled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ledPortOe <= '0;
            ledPortOut <= '0;
        end else begin
            ledPortOe <= ledOn;
            ledPortOut <= '0;
        end
    end

    // readback after write to the same address
    property p_readback(logic [7:0] a);
        @(posedge clk) disable iff (!rst_n)
        (regWrEn && regAddr == a) ##1 (regRdEn && !regWrEn && regAddr == a)
            |=> (regRdData == $past(regWrData, 2));
    endproperty

    a_pair10_readback: assert property (p_readback(`PIO_ADDR_PAIR10)) // RULE_01
        else $error("pair 1/0 readback mismatch");
    a_pair32_readback: assert property (p_readback(`PIO_ADDR_PAIR32)) // RULE_02
        else $error("pair 3/2 readback mismatch");
    a_pair54_readback: assert property (p_readback(`PIO_ADDR_PAIR54)) // RULE_03
        else $error("pair 5/4 readback mismatch");
    a_pair76_readback: assert property (p_readback(`PIO_ADDR_PAIR76)) // RULE_04
        else $error("pair 7/6 readback mismatch");
    a_master_readback: assert property (p_readback(`PIO_ADDR_MASTER)) // RULE_08
        else $error("master readback mismatch");

    // unmapped read answers zero, valid follows strobe
    a_unmapped_read: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
        (regRdEn && !rdDec[3]) |=> (regRdValid && regRdData == `PIO_READ_UNMAPPED))
        else $error("unmapped read not zero");

    // duty: off past the code slot, on inside it at full master
    a_duty_off_slot: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
        (activeMaster_ff == `PIO_MASTER_FULL && activeCode_ff[0] != `PIO_CODE_STATIC
            && slot_ff > activeCode_ff[0]) |=> !ledPortOe[0])
        else $error("output 0 on past its duty");
    a_duty_on_slot: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
        (activeMaster_ff == `PIO_MASTER_FULL && slot_ff <= activeCode_ff[0]) |=> ledPortOe[0])
        else $error("output 0 off inside its duty");

    // static code holds on for the whole period
    a_static_hold: assert property (@(posedge clk) disable iff (!rst_n) // RULE_06
        (!oscOff && storedMaster == activeMaster_ff && activeCode_ff[1] == `PIO_CODE_STATIC
            && !periodStart)[*2] |=> ledPortOe[1])
        else $error("static output 1 not held");

    // master zero stops all drive two cycles later
    a_master_stop: assert property (@(posedge clk) disable iff (!rst_n) // RULE_09
        oscOff |-> ##2 (ledPortOe == '0))
        else $error("outputs driven with master off");
    a_osc_held: assert property (@(posedge clk) disable iff (!rst_n) // RULE_09
        oscOff |=> (slot_ff == 4'h0 && sub_ff == 4'h0))
        else $error("counters run with oscillator off");

    // latched settings change only at a period start
    a_code_latch: assert property (@(posedge clk) disable iff (!rst_n) // RULE_10
        !periodStart |=> ($stable(activeCode_ff) && $stable(activeMaster_ff)))
        else $error("code changed mid period");

    c_full_period: cover property (@(posedge clk) disable iff (!rst_n)
        activeMaster_ff == `PIO_MASTER_FULL && periodStart && !oscOff);
    c_static_code: cover property (@(posedge clk) disable iff (!rst_n)
        activeCode_ff[1] == `PIO_CODE_STATIC && activeMaster_ff != `PIO_MASTER_OFF);
    c_write_read: cover property (@(posedge clk) disable iff (!rst_n)
        (regWrEn && regAddr == `PIO_ADDR_PAIR10) ##1 (regRdEn && regAddr == `PIO_ADDR_PAIR10));
    c_master_off: cover property (@(posedge clk) disable iff (!rst_n)
        !oscOff ##1 oscOff);
endmodule

// file: testbench/pio_host_model.sv
// host model: register writes and reads toward the intensity block
module pio_host_model (
    // clock
    input wire logic clk,
    // register port toward the block
    output logic [7:0] regAddr,
    output logic [7:0] regWrData,
    output logic regWrEn,
    output logic regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic regRdValid
);
    timeunit 1ns;
    timeprecision 1ps;

    bit timedOut; // a read answer never came

    // idle levels at time zero
    initial begin
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        timedOut = 1'b0;
    end

    // one write strobe; lines scrambled once taken so stale data cannot pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
    endtask

    // one read strobe, answer taken when valid shows, bounded wait
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int i;
        @(posedge clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk);
        regRdEn <= 1'b0;
        regAddr <= ~a;
        #1;
        for (i = 0; i < 4 && regRdValid !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (regRdValid !== 1'b1) timedOut = 1'b1;
        d = regRdData;
    endtask

    // write, then read the same address on the very next edge
    task automatic wrrd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
        regRdEn <= 1'b1;
        regWrData <= ~d;
        @(posedge clk);
        regRdEn <= 1'b0;
        regAddr <= ~a;
        #1;
        if (regRdValid !== 1'b1) timedOut = 1'b1;
        q = regRdData;
    endtask
endmodule

// file: testbench/per_output_intensity_pwm_test.sv
// self-checking bench of the per-output intensity pwm block
module per_output_intensity_pwm_test;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TICK = 1; // clocks per sub-step
    localparam int PERIOD = 16 * 15 * TICK; // clocks per pwm period

    logic clk; // 25 MHz clock
    logic rst_n; // async reset
    logic [7:0] regAddr, regWrData, regRdData; // register port
    logic regWrEn, regRdEn, regRdValid; // strobes
    logic [8:0] ledPortOut, ledPortOe; // led ports
    int error_cnt; // mismatches
    int check_count; // comparisons
    logic [15:0] cnt [9]; // sink cycles per port

    // 40 ns clock
    always #20 clk = ~clk;

    pio_host_model host_u (.clk(clk), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .regRdValid(regRdValid));

    pio_top #(.TICK_DIV(TICK)) dut_u (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData(regRdData), .regRdValid(regRdValid), .ledPortOut(ledPortOut),
        .ledPortOe(ledPortOe));

    // compare one value
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // verdict and end of run
    task automatic conclude();
        if (error_cnt == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // read one address and compare
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host_u.rd(a, d);
        chk("read word", {8'h00, exp}, {8'h00, d});
    endtask

    // sink cycles of every port over one period
    task automatic measure();
        int c;
        int p;
        for (p = 0; p < 9; p++) cnt[p] = 16'h0000;
        for (c = 0; c < PERIOD; c++) begin
            @(posedge clk);
            #1;
            for (p = 0; p < 9; p++) cnt[p] = cnt[p] + {15'h0000, ledPortOe[p]};
        end
    endtask

    // wait for a period start seen on port 0, counting port 1 meanwhile
    task automatic wait_rise(output int seen1);
        int i;
        logic prev;
        prev = 1'b1;
        seen1 = 0;
        for (i = 0; i < 2 * PERIOD; i++) begin
            @(posedge clk);
            #1;
            if (ledPortOe[0] === 1'b1 && prev === 1'b0) break;
            if (ledPortOe[1] !== 1'b0) seen1++;
            prev = ledPortOe[0];
        end
        if (i == 2 * PERIOD) begin
            error_cnt++;
            conclude();
        end
    endtask

    // reset state: every word clear, unmapped reads zero, ports idle
    task automatic test_reset();
        int a;
        for (a = 8'h0e; a <= 8'h14; a++) rdchk(8'(a), 8'h00);
        measure();
        for (a = 0; a < 9; a++) chk("idle sink", 16'h0000, cnt[a]);
    endtask

    // pair registers back to back, unmapped write ignored, read back
    task automatic test_map();
        int a;
        for (a = 8'h10; a <= 8'h13; a++) host_u.wr(8'(a), {4'(a), 4'(~a)});
        host_u.wr(8'h14, 8'hff);
        host_u.wr(8'h0e, 8'h0a);
        for (a = 8'h10; a <= 8'h13; a++) begin
            rdchk(8'(a), {4'(a), 4'(~a)});
        end
        rdchk(8'h14, 8'h00);
        rdchk(8'h0e, 8'h0a);
    endtask

    // write then read in the next cycle, every mapped address
    task automatic test_b2b();
        logic [7:0] q;
        int a;
        for (a = 8'h10; a <= 8'h13; a++) begin
            host_u.wrrd(8'(a), 8'(a * 5), q);
            chk("b2b read", {8'h00, 8'(a * 5)}, {8'h00, q});
        end
        host_u.wrrd(8'h0e, 8'h09, q);
        chk("b2b master", 16'h0009, {8'h00, q});
    endtask

    // codes base..base+8 on ports 0..8, master full, duty per port
    task automatic test_duty(input logic [3:0] base);
        logic [3:0] c [9];
        logic [15:0] e; // expected sink cycles
        int p;
        for (p = 0; p < 9; p++) c[p] = base + 4'(p);
        for (p = 0; p < 4; p++) begin
            host_u.wr(8'h10 + 8'(p), {c[2*p+1], c[2*p]});
        end
        host_u.wr(8'h0e, {4'hf, c[8]});
        repeat (PERIOD + 2) @(posedge clk);
        measure();
        for (p = 0; p < 9; p++) begin
            e = (c[p] == 4'hf) ? 16'(PERIOD) : 16'((c[p] + 1) * 15 * TICK);
            chk("sink cycles", e, cnt[p]);
        end
        chk("drive level", 16'h0000, {7'h00, ledPortOut});
    endtask

    // code changed mid-period applies from the next period only
    task automatic test_defer();
        int seen;
        host_u.wr(8'h10, 8'h00);
        repeat (PERIOD + 2) @(posedge clk);
        wait_rise(seen);
        repeat (100) @(posedge clk);
        host_u.wr(8'h10, 8'he0);
        wait_rise(seen);
        chk("old period sink", 16'h0000, 16'(seen));
        measure();
        chk("new period sink", 16'(15 * 15 * TICK), cnt[1]);
    endtask

    // master zero stops all drive whatever the codes
    task automatic test_stop();
        int p;
        host_u.wr(8'h0e, 8'h0e);
        repeat (2) @(posedge clk);
        measure();
        for (p = 0; p < 9; p++) chk("stopped sink", 16'h0000, cnt[p]);
    endtask

    // main sequence
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        error_cnt = 0;
        check_count = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        test_reset();
        test_map();
        test_b2b();
        test_duty(4'h0);
        test_duty(4'h7);
        test_duty(4'he);
        test_defer();
        test_stop();
        if (host_u.timedOut) error_cnt++;
        conclude();
    end
endmodule
